// >>> pqu_defines.vh
// constants for the product/quotient unit: opcodes, widths, latencies
// assumes it is included by bare name from the unit's design files
`ifndef PQU_DEFINES_VH
`define PQU_DEFINES_VH

// datapath and accumulator geometry
`define PQU_DATA_W 32
`define PQU_ACC_PAIRS 4
`define PQU_SEL_W 2
`define PQU_OP_W 4
`define PQU_DEST_W 5

// operation codes presented on op_code
`define PQU_OP_ACC_PRODUCT 4'h0
`define PQU_OP_PRODUCT_ACCUMULATE 4'h1
`define PQU_OP_PRODUCT_SUBTRACT 4'h2
`define PQU_OP_PRODUCT_TO_GPR 4'h3
`define PQU_OP_QUOTIENT 4'h4
`define PQU_OP_MOVE_FROM_UPPER 4'h5
`define PQU_OP_MOVE_FROM_BOTTOM 4'h6
`define PQU_OP_ACC_SHIFT 4'h7
`define PQU_OP_DOT_ACCUMULATE 4'h8
`define PQU_OP_DOT_ACCUMULATE_SAT 4'h9
`define PQU_OP_PAIR_PRODUCT 4'ha

// multiply pipeline latency in clocks, issue edge to result edge
`define PQU_MUL_LAT 5

// early-in iteration skips by dividend width class
`define PQU_DIV_SKIP_8 6'h17
`define PQU_DIV_SKIP_16 6'h0f
`define PQU_DIV_SKIP_24 6'h07
`define PQU_DIV_SKIP_32 6'h00

// divide latency in clocks (unsigned form); signed form adds the fix-up
`define PQU_DIV_LAT_8 6'h0c
`define PQU_DIV_LAT_16 6'h14
`define PQU_DIV_LAT_24 6'h1c
`define PQU_DIV_LAT_32 6'h24
`define PQU_DIV_SIGN_FIX 6'h02

// saturation bounds for a 64-bit accumulator
`define PQU_SAT_MAX 64'h7fff_ffff_ffff_ffff
`define PQU_SAT_MIN 64'h8000_0000_0000_0000

`endif

// >>> pqu_divider.v
// iterative one-bit-per-clock divider with early-in skipping
// assumes start is only pulsed while busy is low; clk_en freezes all state
`timescale 1ns/1ps
`include "pqu_defines.vh"

module pqu_divider
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clk_en,
  input wire start,
  input wire signed_op,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg busy_q,
  output wire done,
  output wire [31:0] quotient,
  output wire [31:0] remainder
);

  reg [5:0] cnt_q;
  reg [5:0] bits_q;
  reg [31:0] dd_q;
  reg [31:0] dv_q;
  reg [31:0] quo_q;
  reg [32:0] rem_q;
  reg negq_q;
  reg negr_q;
  reg [5:0] skip;
  reg [5:0] lat;
  wire [31:0] a_mag;
  wire [31:0] b_mag;
  wire fit8;
  wire fit16;
  wire fit24;
  wire [32:0] rem_sh;
  wire [32:0] diff;
  wire [31:0] quo_mag;

  ////////////////////////////////////////////////////////////////////////
  // operand magnitudes and early-in width class
  assign a_mag = (signed_op && dividend[31]) ? (~dividend + 32'h0000_0001) : dividend;
  assign b_mag = (signed_op && divisor[31]) ? (~divisor + 32'h0000_0001) : divisor;
  // sign extension check, zero extension for the unsigned form
  assign fit8 = signed_op ? (dividend[31:7] == {25{dividend[31]}}) : (dividend[31:8] == 24'h00_0000);
  assign fit16 = signed_op ? (dividend[31:15] == {17{dividend[31]}}) : (dividend[31:16] == 16'h0000);
  assign fit24 = signed_op ? (dividend[31:23] == {9{dividend[31]}}) : (dividend[31:24] == 8'h00);

  // skip count and total latency picked per class
  always @*
  begin
    if (fit8)
    begin
      skip = `PQU_DIV_SKIP_8;
      lat = `PQU_DIV_LAT_8;
    end
    else if (fit16)
    begin
      skip = `PQU_DIV_SKIP_16;
      lat = `PQU_DIV_LAT_16;
    end
    else if (fit24)
    begin
      skip = `PQU_DIV_SKIP_24;
      lat = `PQU_DIV_LAT_24;
    end
    else
    begin
      skip = `PQU_DIV_SKIP_32;
      lat = `PQU_DIV_LAT_32;
    end
    if (signed_op)
      lat = lat + `PQU_DIV_SIGN_FIX;
  end

  ////////////////////////////////////////////////////////////////////////
  // restoring step: one quotient bit per clock
  assign rem_sh = {rem_q[31:0], dd_q[31]};
  assign diff = rem_sh - {1'b0, dv_q};
  assign done = busy_q && (cnt_q == 6'h00);
  // sign fix-up on the way out; divide by zero yields an all-ones quotient magnitude before the fix-up
  // skipped leading bits never get shifted in, so a zero divisor is forced here
  assign quo_mag = (dv_q == 32'h0000_0000) ? 32'hffff_ffff : quo_q;
  assign quotient = negq_q ? (~quo_mag + 32'h0000_0001) : quo_mag;
  assign remainder = negr_q ? (~rem_q[31:0] + 32'h0000_0001) : rem_q[31:0];

  // sequencer: padding cycles after the last bit hold the documented latency
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      bits_q <= 6'h00;
      dd_q <= 32'h0000_0000;
      dv_q <= 32'h0000_0000;
      quo_q <= 32'h0000_0000;
      rem_q <= 33'h0_0000_0000;
      negq_q <= 1'b0;
      negr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q <= lat - 6'h01;
        bits_q <= 6'd32 - skip;
        dd_q <= a_mag << skip; // leading bits already known zero
        dv_q <= b_mag;
        quo_q <= 32'h0000_0000;
        rem_q <= 33'h0_0000_0000;
        negq_q <= signed_op && (dividend[31] ^ divisor[31]);
        negr_q <= signed_op && dividend[31];
      end
      else if (busy_q)
      begin
        if (cnt_q == 6'h00)
          busy_q <= 1'b0;
        else
          cnt_q <= cnt_q - 6'h01;
        if (bits_q != 6'h00)
        begin
          bits_q <= bits_q - 6'h01;
          dd_q <= {dd_q[30:0], 1'b0};
          rem_q <= diff[32] ? rem_sh : diff;
          quo_q <= {quo_q[30:0], ~diff[32]};
        end
      end
    end
  end

endmodule // pqu_divider

// >>> pqu_top.v
// product/quotient unit: multiply pipeline, accumulator pairs, divider
// assumes the integer pipeline holds an op while busy is high
//
// Contract
// - a multiply-class op is taken on every enabled clock while no divide runs.
// - the product is a 32 by 32 multiply of source_operand_one by source_operand_two.
// - four upper/bottom accumulator pairs exist; each result except the moves and plain pair multiply lands in the selected pair.
// - divide resolves one quotient bit per clock in an iterative sequencer.
// - early-in skips 23, 15 or 7 iterations for 8, 16 or 24 bit dividends.
// - divide latency and repeat are 12/14, 20/22, 28/30 and 36/38 clocks by width.
// - any op offered while a divide runs is held off until the divide ends.
// - the multiply pipeline keeps moving regardless of integer pipeline stalls.
// - accumulator multiplies and the register-target multiply finish 5 clocks after issue.
// - the register-target multiply writes its low product half straight to a register.
// - multiply-accumulate adds the product to the selected pair.
// - multiply-subtract takes the product away from the selected pair.
// - move-from-upper and move-from-bottom return a pair half to the chosen register.
// - dot-product, saturating dot-product and plain pair multiply take 5 clocks, repeat 1.
// - accumulator shifts are supported over all four pairs.
`timescale 1ns/1ps
`include "pqu_defines.vh"

module pqu_top
#(
  parameter MUL_LAT = `PQU_MUL_LAT
)
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clk_en,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire op_signed,
  input wire [1:0] op_acc_sel,
  input wire [4:0] op_dest,
  input wire [31:0] source_operand_one,
  input wire [31:0] source_operand_two,
  output wire busy,
  output reg gpr_wr_valid_q,
  output reg [4:0] gpr_wr_dest_q,
  output reg [31:0] gpr_wr_data_q
);

  localparam NP = `PQU_ACC_PAIRS;

  wire issue;
  wire div_busy;
  wire div_done;
  wire [31:0] div_quo;
  wire [31:0] div_rem;
  reg [1:0] div_sel_q;
  wire [32:0] ext_one;
  wire [32:0] ext_two;
  wire [65:0] prod66;
  wire signed [31:0] dot_hi;
  wire signed [31:0] dot_lo;
  wire [63:0] dot64;
  reg [63:0] stage_data;
  reg pv_q [0:MUL_LAT-1];
  reg [3:0] pk_q [0:MUL_LAT-1];
  reg [1:0] ps_q [0:MUL_LAT-1];
  reg [4:0] pdst_q [0:MUL_LAT-1];
  reg [63:0] pd_q [0:MUL_LAT-1];
  wire fin_v;
  wire [3:0] fin_k;
  wire [1:0] fin_s;
  wire [63:0] fin_p;
  wire [NP*64-1:0] acc_flat;
  wire [63:0] acc_cur;
  wire [64:0] sum65;
  wire [5:0] shamt_neg;
  reg acc_we;
  reg [1:0] acc_ws;
  reg [63:0] acc_wd;
  reg gpr_we;
  reg [31:0] gpr_wd;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // issue: refused while the divider runs; busy is the divider's own flop
  assign issue = clk_en && op_valid && !div_busy;
  assign busy = div_busy;

  pqu_divider u_div
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(issue && (op_code == `PQU_OP_QUOTIENT)),
    .signed_op(op_signed),
    .dividend(source_operand_one),
    .divisor(source_operand_two),
    .busy_q(div_busy),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  // remember which pair the running divide targets
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      div_sel_q <= 2'h0;
    else if (issue && (op_code == `PQU_OP_QUOTIENT))
      div_sel_q <= op_acc_sel;
  end

  ////////////////////////////////////////////////////////////////////////
  // first stage arithmetic; one extra top bit makes signed and unsigned alike
  assign ext_one = {op_signed & source_operand_one[31], source_operand_one};
  assign ext_two = {op_signed & source_operand_two[31], source_operand_two};
  assign prod66 = $signed(ext_one) * $signed(ext_two);
  // dot product of signed halfword pairs, widened before the add
  assign dot_hi = $signed(source_operand_one[31:16]) * $signed(source_operand_two[31:16]);
  assign dot_lo = $signed(source_operand_one[15:0]) * $signed(source_operand_two[15:0]);
  assign dot64 = {{32{dot_hi[31]}}, dot_hi} + {{32{dot_lo[31]}}, dot_lo};

  // payload carried down the pipe per op kind
  always @*
  begin
    case (op_code)
      `PQU_OP_ACC_PRODUCT, `PQU_OP_PRODUCT_ACCUMULATE,
      `PQU_OP_PRODUCT_SUBTRACT, `PQU_OP_PRODUCT_TO_GPR:
        stage_data = prod66[63:0];
      `PQU_OP_DOT_ACCUMULATE, `PQU_OP_DOT_ACCUMULATE_SAT:
        stage_data = dot64;
      `PQU_OP_PAIR_PRODUCT:
        stage_data = {{32{dot_lo[31]}}, dot_lo};
      `PQU_OP_ACC_SHIFT:
        stage_data = {58'h0, source_operand_two[5:0]};
      default:
        stage_data = 64'h0000_0000_0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // fixed-depth pipe; it has no stall input, so it drains under core stalls
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < MUL_LAT; i = i + 1)
      begin
        pv_q[i] <= 1'b0;
        pk_q[i] <= 4'h0;
        ps_q[i] <= 2'h0;
        pdst_q[i] <= 5'h00;
        pd_q[i] <= 64'h0000_0000_0000_0000;
      end
    end
    else if (clk_en)
    begin
      pv_q[0] <= issue && (op_code != `PQU_OP_QUOTIENT);
      pk_q[0] <= op_code;
      ps_q[0] <= op_acc_sel;
      pdst_q[0] <= op_dest;
      pd_q[0] <= stage_data;
      for (i = 1; i < MUL_LAT; i = i + 1)
      begin
        pv_q[i] <= pv_q[i-1];
        pk_q[i] <= pk_q[i-1];
        ps_q[i] <= ps_q[i-1];
        pdst_q[i] <= pdst_q[i-1];
        pd_q[i] <= pd_q[i-1];
      end
    end
  end

  assign fin_v = pv_q[MUL_LAT-1];
  assign fin_k = pk_q[MUL_LAT-1];
  assign fin_s = ps_q[MUL_LAT-1];
  assign fin_p = pd_q[MUL_LAT-1];

  ////////////////////////////////////////////////////////////////////////
  // final stage: reads the pair late so back-to-back accumulates chain
  assign acc_cur = acc_flat[fin_s*64 +: 64];
  assign sum65 = {acc_cur[63], acc_cur} + {fin_p[63], fin_p};
  assign shamt_neg = ~fin_p[5:0] + 6'h01;

  always @*
  begin
    acc_we = 1'b0;
    acc_ws = fin_s;
    acc_wd = acc_cur;
    gpr_we = 1'b0;
    gpr_wd = 32'h0000_0000;
    if (fin_v)
    begin
      case (fin_k)
        `PQU_OP_ACC_PRODUCT:
        begin
          acc_we = 1'b1;
          acc_wd = fin_p;
        end
        `PQU_OP_PRODUCT_ACCUMULATE, `PQU_OP_DOT_ACCUMULATE:
        begin
          acc_we = 1'b1;
          acc_wd = acc_cur + fin_p;
        end
        `PQU_OP_PRODUCT_SUBTRACT:
        begin
          acc_we = 1'b1;
          acc_wd = acc_cur - fin_p;
        end
        `PQU_OP_DOT_ACCUMULATE_SAT:
        begin
          acc_we = 1'b1;
          // clamp only when the 65-bit sum leaves the 64-bit range
          if (sum65[64] != sum65[63])
            acc_wd = sum65[64] ? `PQU_SAT_MIN : `PQU_SAT_MAX;
          else
            acc_wd = sum65[63:0];
        end
        `PQU_OP_ACC_SHIFT:
        begin
          acc_we = 1'b1;
          // positive amount shifts right arithmetically, negative shifts left
          if (fin_p[5])
            acc_wd = acc_cur << shamt_neg;
          else
            acc_wd = $signed(acc_cur) >>> fin_p[5:0];
        end
        `PQU_OP_PRODUCT_TO_GPR:
        begin
          acc_we = 1'b1; // pair also gets the product
          acc_wd = fin_p;
          gpr_we = 1'b1;
          gpr_wd = fin_p[31:0];
        end
        `PQU_OP_PAIR_PRODUCT:
        begin
          gpr_we = 1'b1;
          gpr_wd = fin_p[31:0];
        end
        `PQU_OP_MOVE_FROM_UPPER:
        begin
          gpr_we = 1'b1;
          gpr_wd = acc_cur[63:32];
        end
        `PQU_OP_MOVE_FROM_BOTTOM:
        begin
          gpr_we = 1'b1;
          gpr_wd = acc_cur[31:0];
        end
        default:
          acc_we = 1'b0;
      endcase
    end
    // divide completion; the pipe is empty by then since issue was held
    if (div_done)
    begin
      acc_we = 1'b1;
      acc_ws = div_sel_q;
      acc_wd = {div_rem, div_quo};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator pairs: upper half in [63:32], bottom half in [31:0]
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1)
    begin : g_pair
      reg [63:0] pair_q;
      always @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          pair_q <= 64'h0000_0000_0000_0000;
        else if (clk_en && acc_we && (acc_ws == g))
          pair_q <= acc_wd;
      end
      assign acc_flat[g*64 +: 64] = pair_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register-file write port back to the integer pipeline
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gpr_wr_valid_q <= 1'b0;
      gpr_wr_dest_q <= 5'h00;
      gpr_wr_data_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      gpr_wr_valid_q <= gpr_we;
      gpr_wr_dest_q <= pdst_q[MUL_LAT-1];
      gpr_wr_data_q <= gpr_wd;
    end
  end

endmodule // pqu_top

// >>> pqu_chk.sv
// port-level timing checker for the product/quotient unit
// assumes it is bound to pqu_top and clk_en is held high by the bench
`timescale 1ns/1ps
module pqu_chk
#(
  parameter MUL_LAT = 5
)
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clk_en,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [4:0] op_dest,
  input wire [31:0] source_operand_one,
  input wire [31:0] source_operand_two,
  input wire busy,
  input wire gpr_wr_valid_q,
  input wire [4:0] gpr_wr_dest_q,
  input wire [31:0] gpr_wr_data_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // issue decode as the unit sees it; busy is the stall
  wire tk = op_valid && clk_en && !busy;
  wire div_tk = tk && op_code == 4'h4;
  wire reg_tk = tk && (op_code == 4'h3 || op_code == 4'h5 || op_code == 4'h6 || op_code == 4'ha);
  wire [31:0] prod_lo = source_operand_one * source_operand_two;
  ////////////////////////////////////////////////////////////////
  property p_reg_lat;
    reg_tk |-> ##(MUL_LAT+1) gpr_wr_valid_q && gpr_wr_dest_q == $past(op_dest, MUL_LAT+1);
  endproperty
  a_reg_lat: assert property (p_reg_lat) else $error("register result late or bad tag");
  property p_no_spur;
    gpr_wr_valid_q |-> $past(reg_tk, MUL_LAT+1);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("register result without cause");
  property p_mul_data;
    tk && op_code == 4'h3 |-> ##(MUL_LAT+1) gpr_wr_data_q == $past(prod_lo, MUL_LAT+1);
  endproperty
  a_mul_data: assert property (p_mul_data) else $error("low product half wrong");
  property p_back2back;
    reg_tk ##1 reg_tk |-> ##(MUL_LAT) gpr_wr_valid_q [*2];
  endproperty
  a_back2back: assert property (p_back2back) else $error("back-to-back issue lost");
  property p_div_busy;
    div_tk |=> busy;
  endproperty
  a_div_busy: assert property (p_div_busy) else $error("busy missing after divide");
  property p_div_len;
    $rose(busy) |-> busy [*8] ##1 busy [*4] ##[1:27] !busy;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length out of range");
  property p_refuse;
    busy |-> ##(MUL_LAT) !gpr_wr_valid_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("op taken during divide");
  property p_rose_cause;
    $rose(busy) |-> $past(div_tk);
  endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("busy without divide");
  // main scenarios reached
  c_div: cover property (div_tk);
  c_b2b: cover property (reg_tk ##1 reg_tk);
  c_div_end: cover property ($fell(busy));
endmodule // pqu_chk

bind pqu_top pqu_chk #(.MUL_LAT(MUL_LAT)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code), .op_dest(op_dest),
  .source_operand_one(source_operand_one), .source_operand_two(source_operand_two),
  .busy(busy), .gpr_wr_valid_q(gpr_wr_valid_q), .gpr_wr_dest_q(gpr_wr_dest_q),
  .gpr_wr_data_q(gpr_wr_data_q));

// >>> pqu_issue_model.sv
// integer-pipeline stand-in: offers one op, holds it until taken
// assumes issue and idle are called at a falling clock edge
`timescale 1ns/1ps
module pqu_issue_model
(
  input wire clk_sys,
  input wire busy,
  output logic op_valid,
  output logic [3:0] op_code,
  output logic op_signed,
  output logic [1:0] op_acc_sel,
  output logic [4:0] op_dest,
  output logic [31:0] source_operand_one,
  output logic [31:0] source_operand_two
);
  // quiet start values
  initial
  begin
    op_valid = 1'b0;
    op_code = 4'h0;
    op_signed = 1'b0;
    op_acc_sel = 2'h0;
    op_dest = 5'h00;
    source_operand_one = 32'h0000_0000;
    source_operand_two = 32'h0000_0000;
  end
  // offer, then hold everything while stalled
  task automatic issue(input logic [3:0] c, input logic s, input logic [1:0] p,
                       input logic [4:0] d, input logic [31:0] a, input logic [31:0] b);
    begin
      op_valid = 1'b1;
      op_code = c;
      op_signed = s;
      op_acc_sel = p;
      op_dest = d;
      source_operand_one = a;
      source_operand_two = b;
      while (busy !== 1'b0) @(negedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  // released fields flip so stale values never look valid
  task automatic idle;
    begin
      op_valid = 1'b0;
      op_code = ~op_code;
      op_signed = ~op_signed;
      op_acc_sel = ~op_acc_sel;
      op_dest = ~op_dest;
      source_operand_one = ~source_operand_one;
      source_operand_two = ~source_operand_two;
    end
  endtask
endmodule // pqu_issue_model

// >>> mult_div_unit_bench.sv
// self-checking bench: random and corner ops against a pair model
// assumes pqu_top at default latency, clk_en held high
`timescale 1ns/1ps
`include "pqu_defines.vh"
module mult_div_unit_bench;
  logic clk_sys, sys_rst, clk_en;
  wire op_valid, op_signed, busy, gpr_wr_valid_q;
  wire [3:0] op_code;
  wire [1:0] op_acc_sel;
  wire [4:0] op_dest, gpr_wr_dest_q;
  wire [31:0] source_operand_one, source_operand_two, gpr_wr_data_q;
  logic [63:0] acc [4];
  logic [36:0] exp_q [$];
  logic [36:0] e;
  int fail_count, num_checks, run, exp_l;
  pqu_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_signed(op_signed), .op_acc_sel(op_acc_sel), .op_dest(op_dest),
    .source_operand_one(source_operand_one), .source_operand_two(source_operand_two),
    .busy(busy), .gpr_wr_valid_q(gpr_wr_valid_q), .gpr_wr_dest_q(gpr_wr_dest_q),
    .gpr_wr_data_q(gpr_wr_data_q));
  pqu_issue_model m (.clk_sys(clk_sys), .busy(busy), .op_valid(op_valid), .op_code(op_code),
    .op_signed(op_signed), .op_acc_sel(op_acc_sel), .op_dest(op_dest),
    .source_operand_one(source_operand_one), .source_operand_two(source_operand_two));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    begin
      num_checks++;
      if (ok !== 1'b1)
      begin
        fail_count++;
        $display("BAD t=%0t %s", $time, msg);
      end
    end
  endtask
  task automatic stop_test;
    begin
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // divide length by dividend width class, signed form adds fix-up
  function automatic int div_lat(input logic [31:0] a, input logic s);
    logic [31:0] w;
    begin
      w = s ? (a[31] ? ~a : a) : a >> 1;
      div_lat = w[31:7] == 0 ? 12 : w[31:15] == 0 ? 20 : w[31:23] == 0 ? 28 : 36;
      if (s)
        div_lat += 2;
    end
  endfunction
  // model the op in program order, then hand it to the partner
  task automatic op(input logic [3:0] c, input logic s, input logic [1:0] p,
                    input logic [31:0] a, input logic [31:0] b);
    logic [63:0] pr, dt;
    logic [64:0] sm;
    logic [31:0] ma, mb, q, r, pp;
    logic [5:0] sh;
    logic [4:0] d;
    begin
      d = $urandom;
      sh = -b[5:0];
      if (s)
        pr = $signed(a) * $signed(b);
      else
        pr = a * b;
      dt = $signed(a[31:16]) * $signed(b[31:16]) + $signed(a[15:0]) * $signed(b[15:0]);
      pp = $signed(a[15:0]) * $signed(b[15:0]);
      sm = {acc[p][63], acc[p]} + {dt[63], dt};
      ma = (s && a[31]) ? -a : a;
      mb = (s && b[31]) ? -b : b;
      q = mb == 0 ? 32'hffff_ffff : ma / mb;
      r = mb == 0 ? ma : ma % mb;
      if (s && (a[31] ^ b[31]))
        q = -q;
      if (s && a[31])
        r = -r;
      case (c)
        4'h0: acc[p] = pr;
        4'h1: acc[p] = acc[p] + pr;
        4'h2: acc[p] = acc[p] - pr;
        4'h3: begin acc[p] = pr; exp_q.push_back({d, pr[31:0]}); end
        4'h4: acc[p] = {r, q};
        4'h5: exp_q.push_back({d, acc[p][63:32]});
        4'h6: exp_q.push_back({d, acc[p][31:0]});
        4'h7: if (b[5]) acc[p] = acc[p] << sh; else acc[p] = $signed(acc[p]) >>> b[5:0];
        4'h8: acc[p] = sm[63:0];
        4'h9: acc[p] = sm[64] == sm[63] ? sm[63:0] : sm[64] ? `PQU_SAT_MIN : `PQU_SAT_MAX;
        4'ha: exp_q.push_back({d, pp});
        default: ;
      endcase
      m.issue(c, s, p, d, a, b);
      // set only once taken, so the previous divide's length check sees its own figure
      if (c == 4'h4)
        exp_l = div_lat(a, s);
    end
  endtask
  task automatic do_reset;
    begin
      m.idle();
      sys_rst = 1'b1;
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
      for (int i = 0; i < 4; i++)
        acc[i] = 64'h0;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // register results compared in issue order
  always @(negedge clk_sys)
    if (gpr_wr_valid_q === 1'b1)
    begin
      check(exp_q.size() != 0, "register result without cause");
      e = exp_q.size() ? exp_q.pop_front() : ~{gpr_wr_dest_q, gpr_wr_data_q};
      check({gpr_wr_dest_q, gpr_wr_data_q} === e, "register result mismatch");
    end
  // busy run length against the divide class
  always @(negedge clk_sys)
    if (busy === 1'b1)
      run++;
    else if (run != 0)
    begin
      check(run == exp_l, "divide length");
      run = 0;
    end
  // hang guard
  initial
  begin
    #1000000;
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    void'($urandom(91));
    @(negedge clk_sys);
    do_reset();
    for (int i = 0; i < 8; i++)
      op(i[0] ? 4'h5 : 4'h6, 1'b0, i[2:1], 0, 0);
    // saturating dot product driven over the top
    op(4'h0, 1'b1, 2'h2, 32'h8000_0000, 32'h8000_0000);
    op(4'h2, 1'b1, 2'h2, 32'h8000_0000, 32'h7fff_ffff);
    op(4'h9, 1'b1, 2'h2, 32'h8000_8000, 32'h8000_8000);
    op(4'h5, 1'b0, 2'h2, 0, 0);
    // divide by zero, then a move stalled behind a divide
    op(4'h4, 1'b0, 2'h1, 32'h0000_00ff, 32'h0000_0000);
    op(4'h6, 1'b0, 2'h1, 0, 0);
    op(4'h4, 1'b1, 2'h1, 32'h8000_0000, 32'h0000_0003);
    op(4'h6, 1'b0, 2'h1, 0, 0);
    for (int i = 0; i < 300; i++)
      op($urandom_range(0, 15), $urandom, $urandom,
         $urandom >> (8 * $urandom_range(0, 3)), $urandom);
    // pipe drains with no issue offered
    m.idle();
    repeat (45) @(negedge clk_sys);
    check(exp_q.size() == 0, "results missing");
    do_reset();
    op(4'h5, 1'b0, 2'h3, 0, 0);
    m.idle();
    repeat (10) @(negedge clk_sys);
    stop_test();
  end
endmodule // mult_div_unit_bench
